// ### verilog/cbr_map.svh
// constants for the conditional branch decode and execute block
`ifndef CBR_MAP_SVH
`define CBR_MAP_SVH

// ==========================================
// opcode fields
`define CBR_OP_HI_MSB 15
`define CBR_OP_HI_LSB 8
`define CBR_OFS_MSB 7
`define CBR_OFS_LSB 0
`define CBR_OP_OVF_CLEAR 8'hE5
`define CBR_OP_ZERO_CLEAR 8'hE1

// ==========================================
// flag level that lets the branch go
`define CBR_FLAG_CLEAR 1'b0

// ==========================================
// q phase codes inside one instruction cycle
`define CBR_Q1 2'h0
`define CBR_Q2 2'h1
`define CBR_Q3 2'h2
`define CBR_Q4 2'h3

// ==========================================
// reset values
`define CBR_PHASE_RST 2'h0
`define CBR_WORD_RST 16'h0000

`endif

// ### verilog/cbr_pkg.sv
// types shared by the conditional branch block
package cbr_pkg;

  // ==========================================
  // sequencing of one branch instruction
  typedef enum logic [1:0] {
    cbr_idle,
    cbr_exec,
    cbr_nop
  } cbr_state_t;

  // ==========================================
  // which of the two branches was decoded
  typedef enum logic [1:0] {
    cbr_kind_none,
    cbr_kind_ovf,
    cbr_kind_zero
  } cbr_kind_t;

  // ==========================================
  // state of the q phase sequencer
  typedef struct packed {
    logic [1:0] phase;
  } cbr_phase_regs_t;

endpackage

// ### verilog/cbr_qphase.sv
// free-running q phase sequencer, one phase per core clock
`timescale 1ns/10ps
`include "cbr_map.svh"
module cbr_qphase (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // current phase, Q1 to Q4
  output logic [1:0] phase
);

  cbr_pkg::cbr_phase_regs_t r;
  cbr_pkg::cbr_phase_regs_t next_r;

  always_comb begin
    next_r = r;
    next_r.phase = r.phase + 2'h1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r.phase <= `CBR_PHASE_RST;
    end else begin
      r <= next_r;
    end
  end

  assign phase = r.phase;

endmodule

// ### verilog/cbr_target_calc.sv
// branch target adder: advanced counter plus doubled signed offset
`timescale 1ns/10ps
`include "cbr_map.svh"
module cbr_target_calc #(
  parameter int PC_W = 16
) (
  // operands
  input wire logic [PC_W-1:0] pc_base,
  input wire logic [7:0] offset,
  // result
  output logic [PC_W-1:0] target
);

  logic [PC_W-1:0] disp;

  // sign-extend and shift left once so the step counts program words
  assign disp = {{(PC_W-9){offset[`CBR_OFS_MSB]}}, offset, 1'b0}; // RULE5
  assign target = pc_base + disp; // RULE6

endmodule

// ### verilog/cbr_core.sv
// decode and execute of branch-if-overflow-clear and branch-if-zero-clear
// How it works
// RULE1: upper byte E5h decodes branch_if_overflow_clear, low byte is signed offset.
// RULE2: upper byte E1h decodes branch_if_zero_clear, low byte is signed offset.
// RULE3: overflow variant branches only when overflow flag is zero.
// RULE4: zero variant branches only when zero flag is zero.
// RULE5: offset is two's complement, sign-extended and doubled to count words.
// RULE6: taken target is advanced counter plus twice the offset.
// RULE7: one instruction cycle when not taken, two when taken; one word each.
// RULE8: taken first cycle: decode Q1, literal Q2, process Q3, counter write Q4.
// RULE9: taken second cycle is all no-operation, prefetched word discarded.
// RULE10: not taken: decode, literal, process, then no operation in Q4.
// RULE11: status flags never change by these instructions.
// RULE12: condition uses flags as left by previous instruction, sampled before Q4.
`timescale 1ns/10ps
`include "cbr_map.svh"
module cbr_core #(
  parameter int PC_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // fetch side
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [PC_W-1:0] pc_next,
  // status flags
  input wire logic flag_ovf,
  input wire logic flag_zero,
  // program counter side
  output logic pc_load,
  output logic [PC_W-1:0] pc_target,
  output logic flush_fetch,
  // status and sequencing
  output logic flag_write_en,
  output logic instr_done,
  output logic branch_taken,
  output logic busy,
  output logic [1:0] q_phase
);

  // ==========================================
  // state
  typedef struct packed {
    cbr_pkg::cbr_state_t st;
    cbr_pkg::cbr_kind_t kind;
    logic [15:0] ir;
    logic [PC_W-1:0] base;
    logic take;
    logic [PC_W-1:0] target;
    logic pc_load;
    logic done;
  } cbr_core_regs_t;

  cbr_core_regs_t r;
  cbr_core_regs_t next_r;
  logic [1:0] phase;
  logic [PC_W-1:0] calc_target;
  logic cond_ok;

  // ==========================================
  // decode helper, used by the sequencer and the checks
  function automatic cbr_pkg::cbr_kind_t decode_kind(input logic [15:0] w);
    logic [7:0] hi;
    hi = w[`CBR_OP_HI_MSB:`CBR_OP_HI_LSB];
    if (hi == `CBR_OP_OVF_CLEAR) begin
      decode_kind = cbr_pkg::cbr_kind_ovf; // RULE1
    end else if (hi == `CBR_OP_ZERO_CLEAR) begin
      decode_kind = cbr_pkg::cbr_kind_zero; // RULE2
    end else begin
      decode_kind = cbr_pkg::cbr_kind_none;
    end
  endfunction

  // ==========================================
  // submodules
  cbr_qphase u_qphase (
    .core_clk(core_clk),
    .rst(rst),
    .phase(phase)
  );

  cbr_target_calc #(
    .PC_W(PC_W)
  ) u_target (
    .pc_base(r.base),
    .offset(r.ir[`CBR_OFS_MSB:`CBR_OFS_LSB]),
    .target(calc_target)
  );

  // ==========================================
  // branch condition on the live flags; read in Q3 only, so the value
  // seen is what the previous instruction left behind
  always_comb begin
    cond_ok = 1'b0;
    unique case (r.kind)
      cbr_pkg::cbr_kind_ovf: cond_ok = (flag_ovf == `CBR_FLAG_CLEAR); // RULE3
      cbr_pkg::cbr_kind_zero: cond_ok = (flag_zero == `CBR_FLAG_CLEAR); // RULE4
      cbr_pkg::cbr_kind_none: cond_ok = 1'b0;
    endcase
  end

  // ==========================================
  // sequencer
  always_comb begin
    next_r = r;
    next_r.pc_load = 1'b0;
    next_r.done = 1'b0;
    unique case (r.st)
      cbr_pkg::cbr_idle: begin
        // only a word presented at Q1 starts an instruction cycle
        if (phase == `CBR_Q1 && instr_valid &&
            decode_kind(instr_word) != cbr_pkg::cbr_kind_none) begin
          next_r.st = cbr_pkg::cbr_exec; // RULE8
          next_r.kind = decode_kind(instr_word);
          next_r.ir = instr_word;
          next_r.base = pc_next; // RULE6
          next_r.take = 1'b0;
        end
      end
      cbr_pkg::cbr_exec: begin
        if (phase == `CBR_Q3) begin
          // flags are sampled here, one phase ahead of the write
          next_r.take = cond_ok; // RULE12
          // an untaken branch keeps the last target standing on the bus
          if (cond_ok) begin
            next_r.target = calc_target; // RULE5
          end
          next_r.pc_load = cond_ok; // RULE8
          next_r.done = !cond_ok; // RULE10
        end else if (phase == `CBR_Q4) begin
          if (r.take) begin
            next_r.st = cbr_pkg::cbr_nop; // RULE7
          end else begin
            next_r.st = cbr_pkg::cbr_idle; // RULE7
          end
        end
      end
      cbr_pkg::cbr_nop: begin
        // a whole dead cycle: the prefetched word is thrown away
        if (phase == `CBR_Q3) begin
          next_r.done = 1'b1; // RULE9
        end else if (phase == `CBR_Q4) begin
          next_r.st = cbr_pkg::cbr_idle; // RULE9
        end
      end
      default: begin
        next_r.st = cbr_pkg::cbr_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r.st <= cbr_pkg::cbr_idle;
      r.kind <= cbr_pkg::cbr_kind_none;
      r.ir <= `CBR_WORD_RST;
      r.base <= '0;
      r.take <= 1'b0;
      r.target <= '0;
      r.pc_load <= 1'b0;
      r.done <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================
  // outputs
  assign pc_load = r.pc_load;
  assign pc_target = r.target;
  assign flush_fetch = (r.st == cbr_pkg::cbr_nop); // RULE9
  // branches only read the flags, never write them
  assign flag_write_en = 1'b0; // RULE11
  assign instr_done = r.done;
  assign branch_taken = r.take;
  assign busy = (r.st != cbr_pkg::cbr_idle);
  assign q_phase = phase;

  // ==========================================
  // checks
  logic start;
  logic [PC_W-1:0] ref_target;
  assign start = (r.st == cbr_pkg::cbr_idle) && (phase == `CBR_Q1) && instr_valid &&
                 (decode_kind(instr_word) != cbr_pkg::cbr_kind_none);
  assign ref_target = r.base +
                      {{(PC_W-9){r.ir[`CBR_OFS_MSB]}}, r.ir[`CBR_OFS_MSB:`CBR_OFS_LSB], 1'b0};

  a_decode_ovf: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    (start && instr_word[`CBR_OP_HI_MSB:`CBR_OP_HI_LSB] == `CBR_OP_OVF_CLEAR)
    |=> (r.st == cbr_pkg::cbr_exec && r.kind == cbr_pkg::cbr_kind_ovf))
    else $error("overflow-clear branch not decoded");

  a_decode_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    (start && instr_word[`CBR_OP_HI_MSB:`CBR_OP_HI_LSB] == `CBR_OP_ZERO_CLEAR)
    |=> (r.st == cbr_pkg::cbr_exec && r.kind == cbr_pkg::cbr_kind_zero))
    else $error("zero-clear branch not decoded");

  a_ovf_cond: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    (r.st == cbr_pkg::cbr_exec && phase == `CBR_Q3 && r.kind == cbr_pkg::cbr_kind_ovf)
    |=> (pc_load == !$past(flag_ovf)))
    else $error("overflow condition wrong");

  a_zero_cond: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    (r.st == cbr_pkg::cbr_exec && phase == `CBR_Q3 && r.kind == cbr_pkg::cbr_kind_zero)
    |=> (pc_load == !$past(flag_zero)))
    else $error("zero condition wrong");

  a_target_value: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    pc_load |-> (pc_target == ref_target))
    else $error("branch target wrong");

  a_cycle_count: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    start |-> ##3 ((instr_done && !pc_load) or (pc_load ##4 instr_done)))
    else $error("instruction length wrong");

  a_load_phase: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    pc_load |-> (phase == `CBR_Q4 && !instr_done))
    else $error("counter written outside Q4");

  a_nop_cycle: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    pc_load |=> (flush_fetch && !pc_load)[*4] ##1 !flush_fetch)
    else $error("dead cycle wrong after taken branch");

  a_no_jump_q4: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    (instr_done && !flush_fetch) |-> (!pc_load && phase == `CBR_Q4 && $stable(pc_target)))
    else $error("counter touched on untaken branch");

  // ==========================================
  // sequencing and hold checks

  a_start_base: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    start |=> (r.base == $past(pc_next)))
    else $error("advanced counter not captured at start");

  a_target_hold: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    !pc_load |-> $stable(pc_target))
    else $error("target moved without a counter write");

  a_taken_flag: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    pc_load |-> branch_taken)
    else $error("counter written without a taken decision");

  a_done_pulse: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    instr_done |=> (!instr_done && !busy))
    else $error("instruction end not a single pulse");

  a_done_q4: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    instr_done |-> (q_phase == `CBR_Q4))
    else $error("instruction ended outside Q4");

  a_load_busy: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    pc_load |-> busy)
    else $error("counter written while idle");

  a_busy_from_q2: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    $rose(busy) |-> (q_phase == `CBR_Q2))
    else $error("instruction started off the Q1 boundary");

  a_phase_wrap: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    (q_phase == `CBR_Q4) |=> (q_phase == `CBR_Q1))
    else $error("phase did not wrap after Q4");

  a_ignore_other: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    (r.st == cbr_pkg::cbr_idle && !start) |=> !busy)
    else $error("foreign word started an instruction");

  a_dead_ir_kept: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    flush_fetch |=> $stable(r.ir))
    else $error("prefetched word taken in the dead cycle");

  a_flush_taken: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    flush_fetch |-> branch_taken)
    else $error("dead cycle without a taken branch");

  a_decision_kept: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    (q_phase == `CBR_Q4) |=> $stable(branch_taken))
    else $error("branch decision moved after sampling");

  c_taken_ovf: cover property (@(posedge core_clk) disable iff (rst)
    pc_load && r.kind == cbr_pkg::cbr_kind_ovf);
  c_taken_zero: cover property (@(posedge core_clk) disable iff (rst)
    pc_load && r.kind == cbr_pkg::cbr_kind_zero);
  c_not_taken: cover property (@(posedge core_clk) disable iff (rst)
    instr_done && !flush_fetch);
  c_back_to_back: cover property (@(posedge core_clk) disable iff (rst)
    instr_done ##1 start);
  c_dead_offer: cover property (@(posedge core_clk) disable iff (rst)
    flush_fetch && instr_valid);

endmodule

// ### tb/cond_branch_not_ovf_not_zero_tb.sv
// self-checking bench for the conditional branch decode and execute block
`timescale 1ns/10ps
`include "cbr_map.svh"
module cond_branch_not_ovf_not_zero_tb;
  localparam int PC_W = 16;
  // ==========================================
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [PC_W-1:0] pc_next = 16'h0000;
  logic flag_ovf = 1'b0;
  logic flag_zero = 1'b0;
  logic pc_load;
  logic [PC_W-1:0] pc_target;
  logic flush_fetch;
  logic flag_write_en;
  logic instr_done;
  logic branch_taken;
  logic busy;
  logic [1:0] q_phase;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int last_tgt = 0;

  cbr_core #(.PC_W(PC_W)) dut (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .pc_next(pc_next), .flag_ovf(flag_ovf), .flag_zero(flag_zero), .pc_load(pc_load),
    .pc_target(pc_target), .flush_fetch(flush_fetch), .flag_write_en(flag_write_en),
    .instr_done(instr_done), .branch_taken(branch_taken), .busy(busy), .q_phase(q_phase)
  );

  always #50 core_clk = ~core_clk;

  // ==========================================
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end

  // ==========================================
  // compares and verdict
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // inputs always move one nanosecond after the rising edge
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // ==========================================
  // one instruction offered at Q1, model computed with integers
  task automatic run(input logic [7:0] op, input logic [7:0] ofs, input logic [PC_W-1:0] pc,
      input logic ovf, input logic zero);
    int n;
    int tgt;
    logic is_br;
    logic take;
    n = 0;
    while (!(q_phase === `CBR_Q1 && busy === 1'b0) && n < 20) begin
      tick();
      n++;
    end
    is_br = (op == `CBR_OP_OVF_CLEAR) || (op == `CBR_OP_ZERO_CLEAR);
    take = is_br && ((op == `CBR_OP_OVF_CLEAR) ? (ovf == `CBR_FLAG_CLEAR) : (zero == `CBR_FLAG_CLEAR));
    tgt = int'(pc) + 2 * int'($signed(ofs));
    instr_valid = 1'b1;
    instr_word = {op, ofs};
    pc_next = pc;
    flag_ovf = ovf;
    flag_zero = zero;
    tick();
    instr_valid = 1'b0;
    instr_word = 16'($urandom);
    chk_bit(busy, is_br);
    tick();
    chk_bit(instr_done, 1'b0);
    tick();
    // flags flip after the sampling phase; the decision must not follow them
    flag_ovf = ~ovf;
    flag_zero = ~zero;
    chk_bit(instr_done, is_br & ~take);
    chk_bit(pc_load, take);
    chk_bit(flag_write_en, 1'b0);
    if (is_br) chk_bit(branch_taken, take);
    chk_pc(pc_target, PC_W'(take ? tgt : last_tgt));
    chk_pc(PC_W'(q_phase), PC_W'(`CBR_Q4));
    if (take) last_tgt = tgt;
    if (take) begin
      for (int i = 0; i < 4; i++) begin
        tick();
        // a branch offered in the dead cycle must be dropped
        instr_valid = (i == 0);
        instr_word = {`CBR_OP_ZERO_CLEAR, 8'h10};
        chk_bit(flush_fetch, 1'b1);
        chk_bit(pc_load, 1'b0);
        chk_bit(instr_done, i == 3);
      end
    end
    tick();
    chk_bit(busy, 1'b0);
    chk_bit(flush_fetch, 1'b0);
  endtask

  // ==========================================
  // main sequence
  initial begin
    int sel;
    void'($urandom(1));
    repeat (6) @(posedge core_clk);
    #1;
    chk_bit(pc_load, 1'b0);
    rst = 1'b0;
    run(`CBR_OP_OVF_CLEAR, 8'h7F, 16'h0100, 1'b0, 1'b1);
    run(`CBR_OP_OVF_CLEAR, 8'h80, 16'h0002, 1'b1, 1'b0);
    run(`CBR_OP_ZERO_CLEAR, 8'h80, 16'h0002, 1'b1, 1'b0);
    run(`CBR_OP_ZERO_CLEAR, 8'h01, 16'hFFFE, 1'b0, 1'b1);
    run(8'hE3, 8'h05, 16'h0040, 1'b0, 1'b0);
    run(`CBR_OP_ZERO_CLEAR, 8'hFF, 16'h1234, 1'b0, 1'b0);
    // a reset between instructions must clear the standing target
    rst = 1'b1;
    last_tgt = 0;
    tick();
    tick();
    chk_bit(busy, 1'b0);
    chk_bit(pc_load, 1'b0);
    chk_pc(pc_target, PC_W'(last_tgt));
    rst = 1'b0;
    for (int k = 0; k < 40; k++) begin
      sel = $urandom_range(2);
      run(sel == 0 ? `CBR_OP_OVF_CLEAR : sel == 1 ? `CBR_OP_ZERO_CLEAR : 8'($urandom),
          8'($urandom), PC_W'($urandom), 1'($urandom), 1'($urandom));
    end
    results();
  end
endmodule
